// ==== core/arsl_pkg.sv ====
// Constants for analog reference selection, reference save and loss detection.
// Assumes one 10 MHz control clock and an AXI4-Lite register bus.
package arsl_pkg;
    localparam int ARSL_CLK_HZ = 10000000;
    localparam int ARSL_LOSS_WINDOW_MS = 400;
    localparam int ARSL_LOSS_WINDOW_CYC = ARSL_LOSS_WINDOW_MS * (ARSL_CLK_HZ / 1000);
    localparam int ARSL_SAMPLE_US = 10000;
    localparam int ARSL_SAMPLE_CYC = ARSL_SAMPLE_US * (ARSL_CLK_HZ / 1000000);
    localparam int ARSL_LOSS_PCT = 10;
    localparam int ARSL_SAMPLES = ARSL_LOSS_WINDOW_MS * 1000 / ARSL_SAMPLE_US;

    localparam logic [4:0] ARSL_FN_NONE = 5'h00;
    localparam logic [4:0] ARSL_FN_AUX1 = 5'h01;
    localparam logic [4:0] ARSL_FN_AUX2 = 5'h02;
    localparam logic [4:0] ARSL_FN_PID_CMD = 5'h03;
    localparam logic [4:0] ARSL_FN_PID_FB = 5'h05;
    localparam logic [4:0] ARSL_FN_RATIO = 5'h06;
    localparam logic [4:0] ARSL_FN_TLIM_A = 5'h07;
    localparam logic [4:0] ARSL_FN_TLIM_B = 5'h08;
    localparam logic [4:0] ARSL_FN_TRQ = 5'h0a;
    localparam logic [4:0] ARSL_FN_TRQ_I = 5'h0b;
    localparam logic [4:0] ARSL_FN_MON = 5'h14;

    localparam logic [9:0] ARSL_RATIO_STOP = 10'h000;
    localparam logic [9:0] ARSL_RATIO_MIN = 10'h014;
    localparam logic [9:0] ARSL_RATIO_MAX = 10'h078;
    localparam logic [9:0] ARSL_RATIO_UNITY = 10'h064;
    localparam logic [9:0] ARSL_RATIO_OFF = 10'h3e7;

    // Register byte offsets
    localparam logic [7:0] ARSL_REG_FSEL = 8'h00;
    localparam logic [7:0] ARSL_REG_CFG = 8'h04;
    localparam logic [7:0] ARSL_REG_KEYREF = 8'h08;
    localparam logic [7:0] ARSL_REG_SAVED = 8'h0c;
    localparam logic [7:0] ARSL_REG_FREQ = 8'h10;
    localparam logic [7:0] ARSL_REG_STAT = 8'h14;
    localparam logic [7:0] ARSL_REG_IRQ_ST = 8'h18;
    localparam logic [7:0] ARSL_REG_IRQ_CLR = 8'h1c;
    localparam logic [7:0] ARSL_REG_IRQ_EN = 8'h20;
    localparam logic [7:0] ARSL_REG_LEVEL = 8'h24;

    localparam logic [14:0] ARSL_FSEL_RST = 15'h0000;
    localparam logic [10:0] ARSL_CFG_RST = 11'h3e7;
    localparam logic [1:0] ARSL_RESP_OK = 2'h0;
    localparam logic [1:0] ARSL_RESP_ERR = 2'h2;

    typedef enum logic [1:0] {
        ARSL_NORMAL = 2'b00,
        ARSL_LOST = 2'b01
    } arsl_state_t;
endpackage

// ==== core/arsl_top.sv ====
// Analog input function routing, keypad reference save and reference loss supervision.
// Assumes analog values arrive already digitised, synchronous to clk, 16 bits unsigned.
//
// Chosen here: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none
module arsl_top
    import arsl_pkg::*;
#(
    parameter int W = 16,
    parameter int SAMPLE_CYC = ARSL_SAMPLE_CYC
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // AXI4-Lite write
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Analog terminals, unfiltered and filtered
    input wire logic [W-1:0] term_a_raw,
    input wire logic [W-1:0] term_b_raw,
    input wire logic [W-1:0] term_c_raw,
    input wire logic [W-1:0] term_a_filt,
    input wire logic [W-1:0] term_b_filt,
    input wire logic [W-1:0] term_c_filt,
    // Frequency sources
    input wire logic [1:0] cmd_src_sel,
    input wire logic [W-1:0] secondary_cmd,
    input wire logic [W-1:0] multistep_cmd,
    input wire logic [1:0] analog_cmd_sel,
    // Keypad and power
    input wire logic save_key,
    input wire logic power_fail,
    input wire logic power_up,
    // Results
    output logic [W-1:0] final_freq,
    output logic decel_stop,
    output logic ref_loss,
    output logic [W-1:0] pid_cmd,
    output logic [W-1:0] pid_fb,
    output logic [W-1:0] tlim_a,
    output logic [W-1:0] tlim_b,
    output logic [W-1:0] trq_cmd,
    output logic [W-1:0] trq_i_cmd,
    output logic [W-1:0] monitor_val,
    output logic irq
);
    localparam int SCW = $clog2(SAMPLE_CYC + 1);
    localparam int NS = ARSL_SAMPLES;

    // Lowest-numbered terminal carrying the code wins
    function automatic logic [W-1:0] pick(input logic [4:0] code, input logic [14:0] fs,
        input logic [W-1:0] a, input logic [W-1:0] b, input logic [W-1:0] c);
        logic [W-1:0] r;
        r = '0;
        if (fs[4:0] == code)
            r = a;
        else if (fs[9:5] == code)
            r = b;
        else if (fs[14:10] == code)
            r = c;
        return r;
    endfunction

    function automatic logic has(input logic [4:0] code, input logic [14:0] fs);
        return (fs[4:0] == code) || (fs[9:5] == code) || (fs[14:10] == code);
    endfunction

    // Percent scaling of a level
    function automatic logic [W-1:0] pct(input logic [W-1:0] v, input logic [9:0] p);
        logic [W+9:0] m;
        m = v * p;
        m = m / (W+10)'(100);
        return (m > (W+10)'({W{1'b1}})) ? {W{1'b1}} : m[W-1:0];
    endfunction

    // Register file
    logic [14:0] fsel_q;
    logic [10:0] cfg_q;
    logic [W-1:0] keyref_q, saved_q;
    logic [1:0] irq_st_q, irq_en_q;

    // AXI4-Lite slave
    logic aw_full_q, w_full_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic bvalid_q, rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] bresp_q, rresp_q;

    assign s_axi_awready = !aw_full_q && !bvalid_q;
    assign s_axi_wready = !w_full_q && !bvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    wire do_wr = aw_full_q && w_full_q && !bvalid_q;
    wire wr_ok = (awaddr_q == ARSL_REG_FSEL) || (awaddr_q == ARSL_REG_CFG) ||
        (awaddr_q == ARSL_REG_KEYREF) || (awaddr_q == ARSL_REG_IRQ_CLR) || (awaddr_q == ARSL_REG_IRQ_EN);
    wire [31:0] wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
    wire [31:0] wmerge_fsel = ({17'h0, fsel_q} & ~wmask) | (wdata_q & wmask);
    wire [31:0] wmerge_cfg = ({21'h0, cfg_q} & ~wmask) | (wdata_q & wmask);
    wire [31:0] wmerge_key = ({{(32-W){1'b0}}, keyref_q} & ~wmask) | (wdata_q & wmask);
    wire [31:0] wmerge_en = ({30'h0, irq_en_q} & ~wmask) | (wdata_q & wmask);
    wire wr_fsel = do_wr && awaddr_q == ARSL_REG_FSEL;
    wire wr_cfg = do_wr && awaddr_q == ARSL_REG_CFG;
    wire wr_key = do_wr && awaddr_q == ARSL_REG_KEYREF;
    wire wr_clr = do_wr && awaddr_q == ARSL_REG_IRQ_CLR && wstrb_q[0];
    wire wr_en = do_wr && awaddr_q == ARSL_REG_IRQ_EN;

    wire [9:0] ratio_in = wmerge_cfg[9:0];
    wire ratio_legal = (ratio_in == ARSL_RATIO_STOP) || (ratio_in == ARSL_RATIO_OFF) ||
        ((ratio_in >= ARSL_RATIO_MIN) && (ratio_in <= ARSL_RATIO_MAX));

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0;
            wstrb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= ARSL_RESP_OK;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_full_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_full_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (do_wr)
            begin
                aw_full_q <= 1'b0;
                w_full_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= (wr_ok && !(wr_cfg && !ratio_legal)) ? ARSL_RESP_OK : ARSL_RESP_ERR;
            end
            else if (bvalid_q && s_axi_bready)
                bvalid_q <= 1'b0;
        end
    end

    // Sampler and loss supervision signals
    logic [W-1:0] analog_raw;
    logic [W-1:0] hist_q [NS];
    logic [SCW-1:0] scnt_q;
    logic [$clog2(NS+1)-1:0] filled_q;
    logic [W-1:0] latched_q;
    arsl_state_t state_q;
    wire [9:0] ratio = cfg_q[9:0];
    wire save_mode = cfg_q[10];

    always_comb
    begin
        case (analog_cmd_sel)
            2'd0: analog_raw = term_a_raw;
            2'd1: analog_raw = term_b_raw;
            default: analog_raw = term_c_raw;
        endcase
    end

    wire tick = (scnt_q == SCW'(SAMPLE_CYC - 1));
    wire [W-1:0] oldest = hist_q[NS-1];
    // drop below 10% of the oldest sample in the window, once the window is filled
    wire drop = (filled_q == ($clog2(NS+1))'(NS)) &&
        (analog_raw < pct(oldest, 10'(ARSL_LOSS_PCT)));
    wire [W-1:0] rec_thr = (ratio == ARSL_RATIO_STOP || ratio == ARSL_RATIO_OFF) ? pct(latched_q, 10'h014) :
        (ratio >= ARSL_RATIO_UNITY) ? latched_q : pct(latched_q, ratio);
    wire recover = (state_q == ARSL_LOST) && tick && (analog_raw > rec_thr);
    wire declare = (state_q == ARSL_NORMAL) && tick && drop;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            scnt_q <= '0;
            filled_q <= '0;
            state_q <= ARSL_NORMAL;
            latched_q <= '0;
            for (int i = 0; i < NS; i++)
                hist_q[i] <= '0;
        end
        else
        begin
            scnt_q <= tick ? '0 : scnt_q + 1'b1;
            if (tick)
            begin
                hist_q[0] <= analog_raw;
                for (int i = 1; i < NS; i++)
                    hist_q[i] <= hist_q[i-1];
                if (filled_q != ($clog2(NS+1))'(NS))
                    filled_q <= filled_q + 1'b1;
            end
            if (declare)
            begin
                state_q <= ARSL_LOST;
                latched_q <= oldest;
            end
            else if (recover)
            begin
                state_q <= ARSL_NORMAL;
                filled_q <= '0;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            fsel_q <= ARSL_FSEL_RST;
            cfg_q <= ARSL_CFG_RST;
            keyref_q <= '0;
            saved_q <= '0;
            irq_en_q <= 2'h0;
        end
        else
        begin
            if (wr_fsel)
                fsel_q <= wmerge_fsel[14:0];
            if (wr_cfg && ratio_legal)
                cfg_q <= wmerge_cfg[10:0];
            if (wr_en)
                irq_en_q <= wmerge_en[1:0];
            if (power_up)
                keyref_q <= saved_q;
            else if (wr_key)
                keyref_q <= wmerge_key[W-1:0];
            if (!save_mode && power_fail)
                saved_q <= keyref_q;
            else if (save_mode && save_key)
                saved_q <= keyref_q;
        end
    end

    // Frequency composition
    // function routing with priority
    wire [W-1:0] aux1 = pick(ARSL_FN_AUX1, fsel_q, term_a_filt, term_b_filt, term_c_filt);
    wire [W-1:0] aux2 = pick(ARSL_FN_AUX2, fsel_q, term_a_filt, term_b_filt, term_c_filt);
    wire [W-1:0] ratio_v = pick(ARSL_FN_RATIO, fsel_q, term_a_filt, term_b_filt, term_c_filt);
    logic [W-1:0] analog_filt, base;
    always_comb
    begin
        case (analog_cmd_sel)
            2'd0: analog_filt = term_a_filt;
            2'd1: analog_filt = term_b_filt;
            default: analog_filt = term_c_filt;
        endcase
        case (cmd_src_sel)
            2'd0: base = keyref_q;
            2'd1: base = analog_filt;
            2'd2: base = secondary_cmd;
            default: base = multistep_cmd;
        endcase
    end
    wire substitute = (state_q == ARSL_LOST) && (ratio != ARSL_RATIO_OFF) && (cmd_src_sel == 2'd1);
    wire [W-1:0] src = substitute ? pct(latched_q, ratio) : base;
    wire [W+1:0] summed = {2'b00, src} + {2'b00, aux2} +
        ((cmd_src_sel <= 2'd1) ? {2'b00, aux1} : '0);
    wire [W-1:0] sat = (summed > (W+2)'({W{1'b1}})) ? {W{1'b1}} : summed[W-1:0];
    // ratio scaling, full scale means unity
    wire [2*W-1:0] scaled = sat * ratio_v;
    wire [W-1:0] fin = has(ARSL_FN_RATIO, fsel_q) ? scaled[2*W-1:W] : sat;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            final_freq <= '0;
            decel_stop <= 1'b0;
            ref_loss <= 1'b0;
            pid_cmd <= '0;
            pid_fb <= '0;
            tlim_a <= '0;
            tlim_b <= '0;
            trq_cmd <= '0;
            trq_i_cmd <= '0;
            monitor_val <= '0;
            irq_st_q <= 2'h0;
        end
        else
        begin
            final_freq <= fin;
            decel_stop <= substitute && ratio == ARSL_RATIO_STOP;
            ref_loss <= (state_q == ARSL_LOST);
            pid_cmd <= pick(ARSL_FN_PID_CMD, fsel_q, term_a_filt, term_b_filt, term_c_filt);
            pid_fb <= pick(ARSL_FN_PID_FB, fsel_q, term_a_filt, term_b_filt, term_c_filt);
            tlim_a <= pick(ARSL_FN_TLIM_A, fsel_q, term_a_filt, term_b_filt, term_c_filt);
            tlim_b <= pick(ARSL_FN_TLIM_B, fsel_q, term_a_filt, term_b_filt, term_c_filt);
            trq_cmd <= pick(ARSL_FN_TRQ, fsel_q, term_a_filt, term_b_filt, term_c_filt);
            trq_i_cmd <= pick(ARSL_FN_TRQ_I, fsel_q, term_a_filt, term_b_filt, term_c_filt);
            monitor_val <= pick(ARSL_FN_MON, fsel_q, term_a_filt, term_b_filt, term_c_filt);
            // Set wins over clear
            irq_st_q <= (irq_st_q & ~(wr_clr ? wdata_q[1:0] : 2'b00)) | {recover, declare};
        end
    end
    assign irq = |(irq_st_q & irq_en_q);

    // Read path
    logic [31:0] rd_mux;
    logic rd_ok;
    always_comb
    begin
        rd_ok = 1'b1;
        case (s_axi_araddr)
            ARSL_REG_FSEL: rd_mux = {17'h0, fsel_q};
            ARSL_REG_CFG: rd_mux = {21'h0, cfg_q};
            ARSL_REG_KEYREF: rd_mux = 32'(keyref_q);
            ARSL_REG_SAVED: rd_mux = 32'(saved_q);
            ARSL_REG_FREQ: rd_mux = 32'(final_freq);
            ARSL_REG_STAT: rd_mux = {30'h0, decel_stop, ref_loss};
            ARSL_REG_IRQ_ST: rd_mux = {30'h0, irq_st_q};
            ARSL_REG_IRQ_CLR: rd_mux = 32'h0;
            ARSL_REG_IRQ_EN: rd_mux = {30'h0, irq_en_q};
            ARSL_REG_LEVEL: rd_mux = 32'(latched_q);
            default:
            begin
                rd_mux = 32'h0;
                rd_ok = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0;
            rresp_q <= ARSL_RESP_OK;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_mux;
            rresp_q <= rd_ok ? ARSL_RESP_OK : ARSL_RESP_ERR;
        end
        else if (rvalid_q && s_axi_rready)
            rvalid_q <= 1'b0;
    end
endmodule
`default_nettype wire

// ==== sim/arsl_top_props.sv ====
// Checker for arsl_top: bus answers, loss flags and reset quiet state.
// Sees only top ports; one clock, asynchronous active-low reset.
`timescale 1ns/1ns
`default_nettype none
module arsl_top_props
#(
    parameter int W = 16
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Bus
    input wire logic s_axi_awready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Analog side
    input wire logic [W-1:0] term_a_raw,
    input wire logic [1:0] analog_cmd_sel,
    input wire logic [W-1:0] final_freq,
    input wire logic decel_stop,
    input wire logic ref_loss,
    input wire logic irq
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("write address taken while response pending");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while data pending");
    a_decel_in_loss: assert property (decel_stop |-> ref_loss)
        else $error("stop without loss");
    a_loss_raw_low: assert property ($rose(ref_loss) && analog_cmd_sel == 2'h0 |-> $past(term_a_raw) < 16'h199a)
        else $error("loss with high raw level");
    a_reset_quiet: assert property ($rose(nrst) |-> final_freq == '0 && !ref_loss && !irq)
        else $error("outputs active after reset");
endmodule
`default_nettype wire

// ==== sim/arsl_src_model.sv ====
// Model of the analog source on terminal a: slews gently, or reads zero when cut.
// Assumes the bench changes its controls just after rising edges.
`timescale 1ns/1ns
`default_nettype none
module arsl_src_model
#(
    parameter logic [15:0] STEP = 16'h0100
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Bench controls
    input wire logic [15:0] tgt,
    input wire logic cut,
    // Terminal levels
    output logic [15:0] raw_q,
    output logic [15:0] filt_q
);
    logic [15:0] raw_d;
    // slew limited source
    // Steps are spread so only a cut looks like a broken wire; a cut line is pulled low
    assign raw_d = cut ? 16'h0000 : (tgt > raw_q) ? ((tgt - raw_q > STEP) ? raw_q + STEP : tgt)
        : ((raw_q - tgt > STEP) ? raw_q - STEP : tgt);
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            raw_q <= 16'h0000;
            filt_q <= 16'h0000;
        end
        else
        begin
            raw_q <= raw_d;
            filt_q <= raw_q;
        end
    end
endmodule
`default_nettype wire

// ==== sim/arsl_top_test.sv ====
// Self-checking bench for arsl_top: registers, routing, save modes, loss supervision.
// Assumes the source model on terminal a; the sample tick is shortened to 10 cycles.
`timescale 1ns/1ns
`default_nettype none
module arsl_top_test;
    import arsl_pkg::*;
    localparam int W = 16;
    localparam logic [4:0] CODES [7] = '{ARSL_FN_PID_CMD, ARSL_FN_PID_FB, ARSL_FN_TLIM_A, ARSL_FN_TLIM_B,
        ARSL_FN_TRQ, ARSL_FN_TRQ_I, ARSL_FN_MON};
    logic clk = 1'b0, nrst = 1'b0, awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0, cut = 1'b0;
    logic awr, wrdy, bv, arr, rv, decel, loss, irq;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic [1:0] bresp, rresp, src_sel = 2'h0, acs = 2'h0;
    logic [2:0] keys = 3'h0;
    logic [3:0] strb = 4'hf;
    logic [15:0] tgt = 16'h1111, sec = 16'h0500, mstep = 16'h0200;
    logic [15:0] raw_a, filt_a, ffreq, pcmd, pfb, tla, tlb, tq, tqi, mon;
    int bad_count, checks;

    arsl_src_model i_src (.clk(clk), .nrst(nrst), .tgt(tgt), .cut(cut), .raw_q(raw_a), .filt_q(filt_a));
    arsl_top #(.W(W), .SAMPLE_CYC(10)) i_dut (.clk(clk), .nrst(nrst),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wdata),
        .s_axi_wstrb(strb), .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
        .s_axi_bready(br), .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr),
        .term_a_raw(raw_a), .term_b_raw(16'h2222), .term_c_raw(16'h3333), .term_a_filt(filt_a),
        .term_b_filt(16'h2222), .term_c_filt(16'h3333), .cmd_src_sel(src_sel), .secondary_cmd(sec),
        .multistep_cmd(mstep), .analog_cmd_sel(acs), .save_key(keys[0]), .power_fail(keys[1]),
        .power_up(keys[2]), .final_freq(ffreq), .decel_stop(decel), .ref_loss(loss), .pid_cmd(pcmd),
        .pid_fb(pfb), .tlim_a(tla), .tlim_b(tlb), .trq_cmd(tq), .trq_i_cmd(tqi), .monitor_val(mon), .irq(irq));

    initial
    begin
        forever #50 clk = ~clk;
    end

    task automatic summarize();
        if (bad_count == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic ticks(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Ready is combinational on registered state, so its negedge value is the edge value
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw, w;
        aw = 1'b1;
        w = 1'b1;
        awaddr <= a;
        wdata <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        while (aw || w)
        begin
            @(negedge clk);
            aw = aw && (awr !== 1'b1);
            w = w && (wrdy !== 1'b1);
            @(posedge clk);
            awv <= aw;
            wv <= w;
        end
        // Response waits one cycle before bready so its hold is exercised
        do @(negedge clk); while (bv !== 1'b1);
        @(posedge clk);
        br <= 1'b1;
        @(posedge clk);
        chk({30'h0, bresp}, {30'h0, er});
        br <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        araddr <= a;
        arv <= 1'b1;
        do @(negedge clk); while (arr !== 1'b1);
        @(posedge clk);
        arv <= 1'b0;
        do @(negedge clk); while (rv !== 1'b1);
        @(posedge clk);
        rr <= 1'b1;
        @(posedge clk);
        chk(rdata, exp);
        chk({30'h0, rresp}, {30'h0, er});
        rr <= 1'b0;
    endtask

    task automatic pulse(input logic [2:0] m);
        keys <= m;
        ticks(1);
        keys <= 3'h0;
        ticks(2);
    endtask

    function automatic logic [31:0] pick(input logic [4:0] c);
        case (c)
            ARSL_FN_PID_CMD: return {16'h0, pcmd};
            ARSL_FN_PID_FB: return {16'h0, pfb};
            ARSL_FN_TLIM_A: return {16'h0, tla};
            ARSL_FN_TLIM_B: return {16'h0, tlb};
            ARSL_FN_TRQ: return {16'h0, tq};
            ARSL_FN_TRQ_I: return {16'h0, tqi};
            default: return {16'h0, mon};
        endcase
    endfunction

    task automatic t_regs();
        rd(ARSL_REG_CFG, 32'h3e7, ARSL_RESP_OK);
        rd(8'h40, 32'h0, ARSL_RESP_ERR);
        // Only byte 1 enabled, the rest must keep reset value
        strb <= 4'h2;
        wr(ARSL_REG_KEYREF, 32'h0000ffff, ARSL_RESP_OK);
        strb <= 4'hf;
        rd(ARSL_REG_KEYREF, 32'h0000ff00, ARSL_RESP_OK);
        wr(ARSL_REG_CFG, 32'h00000013, ARSL_RESP_ERR);
        wr(ARSL_REG_CFG, 32'h00000096, ARSL_RESP_ERR);
        rd(ARSL_REG_CFG, 32'h3e7, ARSL_RESP_OK);
    endtask

    task automatic t_route();
        ticks(40);
        foreach (CODES[i])
        begin
            wr(ARSL_REG_FSEL, {17'h0, CODES[i], CODES[i], CODES[i]}, ARSL_RESP_OK);
            ticks(3);
            chk(pick(CODES[i]), 32'h1111);
            wr(ARSL_REG_FSEL, {17'h0, CODES[i], CODES[i], 5'h00}, ARSL_RESP_OK);
            ticks(3);
            chk(pick(CODES[i]), 32'h2222);
        end
        wr(ARSL_REG_FSEL, 32'h0, ARSL_RESP_OK);
        ticks(3);
        chk(pick(ARSL_FN_MON), 32'h0);
    endtask

    task automatic t_aux(input logic [1:0] s, input logic [4:0] c, input logic [31:0] exp);
        src_sel <= s;
        acs <= 2'h1;
        wr(ARSL_REG_FSEL, {27'h0, c}, ARSL_RESP_OK);
        ticks(3);
        chk({16'h0, ffreq}, exp);
    endtask

    task automatic t_save();
        src_sel <= 2'h0;
        wr(ARSL_REG_KEYREF, 32'h0123, ARSL_RESP_OK);
        pulse(3'h2);
        rd(ARSL_REG_SAVED, 32'h0123, ARSL_RESP_OK);
        wr(ARSL_REG_KEYREF, 32'h0456, ARSL_RESP_OK);
        pulse(3'h4);
        rd(ARSL_REG_KEYREF, 32'h0123, ARSL_RESP_OK);
        wr(ARSL_REG_CFG, 32'h414, ARSL_RESP_OK);
        wr(ARSL_REG_KEYREF, 32'h0789, ARSL_RESP_OK);
        pulse(3'h2);
        rd(ARSL_REG_SAVED, 32'h0123, ARSL_RESP_OK);
        pulse(3'h1);
        pulse(3'h4);
        rd(ARSL_REG_KEYREF, 32'h0789, ARSL_RESP_OK);
    endtask

    task automatic t_loss(input logic [9:0] ratio, input logic [31:0] freq, input logic dec, input logic [15:0] thr);
        int n;
        src_sel <= 2'h1;
        acs <= 2'h0;
        wr(ARSL_REG_CFG, {22'h0, ratio}, ARSL_RESP_OK);
        // A ratio terminal left from earlier would scale the substitute by the cut line
        wr(ARSL_REG_FSEL, 32'h0, ARSL_RESP_OK);
        cut <= 1'b0;
        tgt <= 16'h4000;
        ticks(600);
        cut <= 1'b1;
        for (n = 0; n < 1000 && loss !== 1'b1; n++)
            ticks(1);
        ticks(2);
        rd(ARSL_REG_STAT, {30'h0, dec, 1'b1}, ARSL_RESP_OK);
        if (ratio != ARSL_RATIO_STOP)
            chk({16'h0, ffreq}, freq);
        rd(ARSL_REG_LEVEL, 32'h4000, ARSL_RESP_OK);
        cut <= 1'b0;
        tgt <= thr;
        ticks(300);
        chk({31'h0, loss}, 32'h1);
        tgt <= thr + 16'h0001;
        ticks(100);
        chk({31'h0, loss}, 32'h0);
    endtask

    task automatic t_irq();
        rd(ARSL_REG_IRQ_ST, 32'h3, ARSL_RESP_OK);
        chk({31'h0, irq}, 32'h0);
        wr(ARSL_REG_IRQ_EN, 32'h1, ARSL_RESP_OK);
        chk({31'h0, irq}, 32'h1);
        wr(ARSL_REG_IRQ_CLR, 32'h3, ARSL_RESP_OK);
        rd(ARSL_REG_IRQ_ST, 32'h0, ARSL_RESP_OK);
        rd(ARSL_REG_IRQ_CLR, 32'h0, ARSL_RESP_OK);
        chk({31'h0, irq}, 32'h0);
    endtask

    initial
    begin
        ticks(6);
        nrst <= 1'b1;
        ticks(1);
        t_regs();
        t_route();
        t_aux(2'h2, ARSL_FN_AUX1, 32'h0500);
        t_aux(2'h1, ARSL_FN_AUX1, 32'h3333);
        t_aux(2'h2, ARSL_FN_AUX2, 32'h1611);
        t_aux(2'h3, ARSL_FN_AUX2, 32'h1311);
        t_aux(2'h2, ARSL_FN_RATIO, 32'h0055);
        t_save();
        t_loss(10'h032, 32'h2000, 1'b0, 16'h2000);
        t_loss(ARSL_RATIO_OFF, 32'h0, 1'b0, 16'h0ccc);
        t_loss(ARSL_RATIO_STOP, 32'h0, 1'b1, 16'h0ccc);
        t_loss(ARSL_RATIO_UNITY, 32'h4000, 1'b0, 16'h4000);
        t_loss(ARSL_RATIO_MAX, 32'h4ccc, 1'b0, 16'h4000);
        t_irq();
        summarize();
    end

    initial
    begin
        ticks(40000);
        bad_count++;
        summarize();
    end
endmodule

bind arsl_top arsl_top_props #(.W(W)) i_props (.clk, .nrst, .s_axi_awready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
    .term_a_raw, .analog_cmd_sel, .final_freq, .decel_stop, .ref_loss, .irq);
`default_nettype wire
